// ---- rtl/rf_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rf_map.svh"
// How it works
// - slope derived from one of three selectable frequency references, Hz/s
// - slope above max-rate setting (0.10 Hz/s steps, 200 default) blocks all
// - each of eight stages has enable, default off; off stage shows nothing
// - forced status Normal/Start/Trip/Blocked acts only when forcing permitted
// - node behaviour On/Blocked/Test/TestBlocked/Off, writable only when allowed
// - started stage releases only 100 mHz/s below its pick-up
// - direction Rising, Falling or Both selects which slope sign operates
// - per-stage switch decides whether frequency limits gate tripping
// - pick-up in 0.01 Hz/s steps, default 0.2 Hz/s
// - stage set Falling trips only below underfrequency limit, default 49.95
// - stage set Rising trips only above overfrequency limit, default 51
// - with limits on, no trip between the two limits
// - stage operates when slope exceeds pick-up in allowed direction
// - one participation flag per stage, shared by all groups; pick-up values changeable while running
// - definite delay from start to trip and for trip release
// - general settings static, unaffected by setting group changes
// - block sampled each program cycle; pick-up under block gives Blocked, resets start
// - ON/OFF events for start, trip, blocked with clearable counters
// - ring of twelve time-stamped records with slope, frequency, group
module rf_top import rf_pkg::*; #(
    parameter int PROG_CYC = `RF_PROG_CYC,
    parameter int MS_CYC = `RF_MS_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire rf_refs_t freq_ref,
    input wire logic [7:0] stage_block,
    output logic [7:0] start,
    output logic [7:0] trip,
    output logic [7:0] blocked
);
    typedef struct packed {
        logic ap_valid;
        logic ap_wr;
        logic [11:0] ap_addr;
        logic [1:0] ref_sel;
        logic force_ok;
        logic mode_allow;
        rf_mode_e mode;
        logic [2:0] grp;
        logic [8:0] maxrate;
        rf_stage_cfg_s [7:0] stg;
        logic [31:0] tick_cnt;
        logic [31:0] ms_cnt;
        logic [31:0] ts;
        logic tick;
        logic fn_blk;
        logic [7:0] start;
        logic [7:0] trip;
        logic [7:0] blocked;
        logic [2:0] agg;
        logic [7:0] cnt_st;
        logic [7:0] cnt_tr;
        logic [7:0] cnt_bk;
        logic [3:0] wptr;
        logic [3:0] rsel;
        rf_rec_s [`RF_REC_DEPTH-1:0] rec;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } rf_top_state_s;

    rf_top_state_s s, s_nxt;
    rf_meas_s meas;
    rf_stage_out_s [7:0] st_out;
    logic upd, over_rate, fn_blk_now, node_blk, cnt_clr, ev_on, rd_hit;
    logic [7:0] blk_eff;
    logic [2:0] agg_n, chg;
    logic [1:0] kind;
    logic [2:0] wi;
    logic [31:0] rd;

    function automatic logic stg_hit(input logic [11:0] a);
        return a[11:7] == `RF_A_STG_HI;
    endfunction : stg_hit

    function automatic logic [2:0] stg_idx(input logic [11:0] a);
        return a[6:4];
    endfunction : stg_idx

    function automatic logic [15:0] mag(input logic signed [15:0] v);
        return v[15] ? 16'(-v) : 16'(v);
    endfunction : mag

    rf_slope u_slope (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(s.tick),
        .refs(freq_ref),
        .ref_sel(s.ref_sel),
        .upd(upd),
        .meas(meas)
    );

    // the max-rate test is taken in the very cycle the new slope lands
    assign over_rate = mag(meas.slope) > 16'(s.maxrate * `RF_RATE_TO_SLOPE);
    assign fn_blk_now = upd ? over_rate : s.fn_blk;
    assign node_blk = (s.mode == RF_M_BLOCKED) || (s.mode == RF_M_TESTBLK);
    assign blk_eff = stage_block | {8{fn_blk_now | node_blk}};

    for (genvar i = 0; i < 8; i++) begin : g_stage
        rf_stage u_stage (
            .hclk(hclk),
            .hresetn(hresetn),
            .upd(upd),
            .cfg(s.stg[i]),
            .slope(meas.slope),
            .freq(meas.freq),
            .blk(blk_eff[i]),
            .force_ok(s.force_ok),
            .st(st_out[i])
        );
    end

    always_comb begin
        s_nxt = s;
        cnt_clr = 1'b0;
        ev_on = 1'b0;
        kind = 2'h0;
        wi = stg_idx(s.ap_addr);
        rd = 32'h0000_0000;
        rd_hit = hsel && htrans[1] && hready && !hwrite && haddr[31:12] == 20'h00000;
        // time base: program cycle and millisecond stamp
        s_nxt.tick = 1'b0;
        if (s.tick_cnt == 32'(PROG_CYC - 1)) begin
            s_nxt.tick_cnt = 32'h0000_0000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.tick_cnt = s.tick_cnt + 32'h0000_0001;
        end
        if (s.ms_cnt == 32'(MS_CYC - 1)) begin
            s_nxt.ms_cnt = 32'h0000_0000;
            s_nxt.ts = s.ts + 32'h0000_0001;
        end else begin
            s_nxt.ms_cnt = s.ms_cnt + 32'h0000_0001;
        end
        s_nxt.fn_blk = fn_blk_now;

        // address phase; no wait states, read data leaves a flop
        s_nxt.ap_valid = hsel && htrans[1] && hready && haddr[31:12] == 20'h00000;
        s_nxt.ap_wr = hwrite;
        s_nxt.ap_addr = haddr[11:0];
        if (stg_hit(haddr[11:0])) begin
            unique case (haddr[3:2])
                2'h0: rd = 32'(s.stg[stg_idx(haddr[11:0])][`RF_CFG_W-1:0]);
                2'h1: rd = {16'h0000, s.stg[stg_idx(haddr[11:0])].pick};
                2'h2: rd = {s.stg[stg_idx(haddr[11:0])].of_lim, s.stg[stg_idx(haddr[11:0])].uf_lim};
                2'h3: rd = {s.stg[stg_idx(haddr[11:0])].rst_dly, s.stg[stg_idx(haddr[11:0])].op_dly};
            endcase
        end else begin
            case (haddr[11:0])
                `RF_A_CTRL: rd = {22'h000000, s.grp, s.mode, s.mode_allow, s.force_ok, s.ref_sel};
                `RF_A_MAXRATE: rd = {23'h000000, s.maxrate};
                `RF_A_STATUS: rd = {7'h00, s.fn_blk, s.blocked, s.trip, s.start};
                `RF_A_MEAS: rd = {meas.freq, meas.slope};
                `RF_A_COUNT: rd = {8'h00, s.cnt_bk, s.cnt_tr, s.cnt_st};
                `RF_A_RSEL: rd = {24'h000000, s.wptr, s.rsel};
                `RF_A_REC0: rd = (s.rsel < 4'hC) ? s.rec[s.rsel].ts : 32'h0000_0000;
                `RF_A_REC1: rd = (s.rsel < 4'hC) ? s.rec[s.rsel].m[63:32] : 32'h0000_0000;
                `RF_A_REC2: rd = (s.rsel < 4'hC) ? s.rec[s.rsel].m[31:0] : 32'h0000_0000;
                `RF_A_REC3: rd = (s.rsel < 4'hC) ? {26'h0, s.rec[s.rsel].grp, s.rec[s.rsel].ev}
                    : 32'h0000_0000;
                default: rd = 32'h0000_0000;
            endcase
        end
        s_nxt.hrdata = rd_hit ? rd : 32'h0000_0000;

        // data phase write; unmapped addresses are dropped with OKAY
        if (s.ap_valid && s.ap_wr) begin
            if (stg_hit(s.ap_addr)) begin
                // pick-up values are one set shared by all groups and may change live
                unique case (s.ap_addr[3:2])
                    2'h0: s_nxt.stg[wi][`RF_CFG_W-1:0] = hwdata[`RF_CFG_W-1:0];
                    2'h1: s_nxt.stg[wi].pick = hwdata[15:0];
                    2'h2: begin
                        s_nxt.stg[wi].uf_lim = hwdata[15:0];
                        s_nxt.stg[wi].of_lim = hwdata[31:16];
                    end
                    2'h3: begin
                        s_nxt.stg[wi].op_dly = hwdata[15:0];
                        s_nxt.stg[wi].rst_dly = hwdata[31:16];
                    end
                endcase
            end else begin
                case (s.ap_addr)
                    `RF_A_CTRL: begin
                        s_nxt.ref_sel = hwdata[1:0];
                        s_nxt.force_ok = hwdata[2];
                        s_nxt.mode_allow = hwdata[3];
                        // group number only tags records; static settings stay put
                        s_nxt.grp = hwdata[9:7];
                        if (s.mode_allow && hwdata[6:4] <= 3'h4) begin
                            s_nxt.mode = rf_mode_e'(hwdata[6:4]);
                        end
                    end
                    `RF_A_MAXRATE: s_nxt.maxrate = hwdata[8:0];
                    `RF_A_COUNT: cnt_clr = 1'b1;
                    `RF_A_RSEL: s_nxt.rsel = hwdata[3:0];
                    default: s_nxt.rsel = s.rsel;
                endcase
            end
        end

        // node behaviour gates what leaves the block
        for (int i = 0; i < 8; i++) begin
            s_nxt.start[i] = st_out[i].start && s.mode != RF_M_OFF;
            s_nxt.trip[i] = st_out[i].trip && s.mode == RF_M_ON;
            s_nxt.blocked[i] = st_out[i].blocked && s.mode != RF_M_OFF;
        end

        // events: function-level ON/OFF edges; one record per cycle, trip first
        agg_n = {|s_nxt.blocked, |s_nxt.trip, |s_nxt.start};
        chg = agg_n ^ s.agg;
        s_nxt.agg = agg_n;
        if (cnt_clr) begin
            s_nxt.cnt_st = 8'h00;
            s_nxt.cnt_tr = 8'h00;
            s_nxt.cnt_bk = 8'h00;
        end
        // an edge in the clearing cycle still counts
        if (agg_n[0] && !s.agg[0]) begin
            s_nxt.cnt_st = (cnt_clr ? 8'h00 : s.cnt_st) + 8'h01;
        end
        if (agg_n[1] && !s.agg[1]) begin
            s_nxt.cnt_tr = (cnt_clr ? 8'h00 : s.cnt_tr) + 8'h01;
        end
        if (agg_n[2] && !s.agg[2]) begin
            s_nxt.cnt_bk = (cnt_clr ? 8'h00 : s.cnt_bk) + 8'h01;
        end
        if (|chg) begin
            if (chg[1]) begin
                kind = 2'h2;
                ev_on = agg_n[1];
            end else if (chg[0]) begin
                kind = 2'h1;
                ev_on = agg_n[0];
            end else begin
                kind = 2'h3;
                ev_on = agg_n[2];
            end
            s_nxt.rec[s.wptr].ts = s.ts;
            s_nxt.rec[s.wptr].m = meas;
            s_nxt.rec[s.wptr].grp = s.grp;
            s_nxt.rec[s.wptr].ev = {ev_on, kind};
            s_nxt.wptr = (s.wptr == 4'hB) ? 4'h0 : s.wptr + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.hreadyout <= 1'b1;
            s.maxrate <= `RF_MAXRATE_RST;
            for (int i = 0; i < 8; i++) begin
                s.stg[i].pick <= `RF_PICK_RST;
                s.stg[i].uf_lim <= `RF_UF_RST;
                s.stg[i].of_lim <= `RF_OF_RST;
            end
        end else begin
            s <= s_nxt;
        end
    end

    assign hrdata = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign start = s.start;
    assign trip = s.trip;
    assign blocked = s.blocked;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_max_rate_block: assert property (
        upd && over_rate |=> s.fn_blk ##1 (s.start == 8'h00))
        else $error("max rate did not block");
    a_node_off_quiet: assert property (
        s.mode == RF_M_OFF |=> s.start == 8'h00 && s.trip == 8'h00 && s.blocked == 8'h00)
        else $error("outputs active with node off");
    a_mode_write_lock: assert property (
        s.ap_valid && s.ap_wr && s.ap_addr == `RF_A_CTRL && !s.mode_allow
        |=> s.mode == $past(s.mode))
        else $error("node behaviour changed while locked");
    a_start_count_step: assert property (
        $rose(|s.start) |-> s.cnt_st == 8'($past(s.cnt_st) + 8'h01) || s.cnt_st == 8'h01)
        else $error("start counter missed an edge");
    a_record_ring_step: assert property (
        s.agg != $past(s.agg) |-> s.wptr != $past(s.wptr) && s.wptr < 4'hC)
        else $error("record pointer did not advance");
    c_start_seen: cover property ($rose(|s.start));
    c_trip_seen: cover property ($rose(|s.trip));
    c_block_seen: cover property ($rose(|s.blocked));
    c_rate_block: cover property ($rose(s.fn_blk));
endmodule : rf_top
`default_nettype wire

// ---- rtl/rf_map.svh ----
`ifndef RF_MAP_SVH
`define RF_MAP_SVH
`define RF_CLK_MHZ 100
`define RF_PROG_MS 5
`define RF_PROG_CYC (`RF_PROG_MS * 1000 * `RF_CLK_MHZ)
`define RF_MS_CYC (1000 * `RF_CLK_MHZ)
`define RF_SLOPE_SCALE (1000 / `RF_PROG_MS)
`define RF_PRE_MS 20
`define RF_PRE_DEPTH (`RF_PRE_MS / `RF_PROG_MS)
`define RF_HYST_MHZS 100
`define RF_HYST (`RF_HYST_MHZS / 10)
`define RF_RATE_TO_SLOPE 10
`define RF_REC_DEPTH 12
`define RF_MAXRATE_RST 9'h0C8
`define RF_PICK_RST 16'h0014
`define RF_UF_RST 16'h1383
`define RF_OF_RST 16'h13EC
`define RF_A_CTRL 12'h000
`define RF_A_MAXRATE 12'h004
`define RF_A_STATUS 12'h008
`define RF_A_MEAS 12'h00C
`define RF_A_COUNT 12'h010
`define RF_A_RSEL 12'h014
`define RF_A_REC0 12'h018
`define RF_A_REC1 12'h01C
`define RF_A_REC2 12'h020
`define RF_A_REC3 12'h024
`define RF_A_STG_HI 5'h02
`define RF_CFG_W 7
`endif

// ---- rtl/rf_pkg.sv ----
package rf_pkg;
    typedef enum logic [1:0] {
        RF_DIR_RISE = 2'b00,
        RF_DIR_FALL = 2'b01,
        RF_DIR_BOTH = 2'b10
    } rf_dir_e;
    typedef enum logic [1:0] {
        RF_F_NORMAL = 2'b00,
        RF_F_START = 2'b01,
        RF_F_TRIP = 2'b10,
        RF_F_BLOCKED = 2'b11
    } rf_force_e;
    typedef enum logic [2:0] {
        RF_M_ON = 3'b000,
        RF_M_BLOCKED = 3'b001,
        RF_M_TEST = 3'b010,
        RF_M_TESTBLK = 3'b011,
        RF_M_OFF = 3'b100
    } rf_mode_e;
    typedef logic [2:0][15:0] rf_refs_t;
    typedef struct packed {
        logic [15:0] rst_dly;
        logic [15:0] op_dly;
        logic [15:0] of_lim;
        logic [15:0] uf_lim;
        logic [15:0] pick;
        logic ingrp;
        logic lim;
        rf_dir_e dir;
        rf_force_e force_st;
        logic en;
    } rf_stage_cfg_s;
    typedef struct packed {
        logic blocked;
        logic trip;
        logic start;
    } rf_stage_out_s;
    typedef struct packed {
        logic signed [15:0] slope;
        logic [15:0] freq;
        logic signed [15:0] pslope;
        logic [15:0] pfreq;
    } rf_meas_s;
    typedef struct packed {
        logic [31:0] ts;
        rf_meas_s m;
        logic [2:0] grp;
        logic [2:0] ev;
    } rf_rec_s;
endpackage : rf_pkg

// ---- rtl/rf_slope.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rf_map.svh"
module rf_slope import rf_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire rf_refs_t refs,
    input wire logic [1:0] ref_sel,
    output logic upd,
    output rf_meas_s meas
);
    typedef struct packed {
        logic primed;
        logic upd;
        logic [15:0] prev;
        rf_meas_s m;
        logic [`RF_PRE_DEPTH-1:0][31:0] hist;
    } rf_slope_state_s;
    rf_slope_state_s s_r, s_nxt;
    logic [15:0] f;
    logic signed [16:0] d;
    logic signed [24:0] p;
    logic signed [15:0] sat;
    always_comb begin
        s_nxt = s_r;
        s_nxt.upd = 1'b0;
        // unused select code falls back to the primary reference
        f = (ref_sel == 2'h1) ? refs[1] : (ref_sel == 2'h2) ? refs[2] : refs[0];
        d = signed'({1'b0, f}) - signed'({1'b0, s_r.prev});
        p = 25'(d) * 25'(`RF_SLOPE_SCALE);
        if (p > 25'sh0007FFF) begin
            sat = 16'sh7FFF;
        end else if (p < -25'sh0008000) begin
            sat = -16'sh8000;
        end else begin
            sat = p[15:0];
        end
        if (tick) begin
            s_nxt.upd = 1'b1;
            s_nxt.primed = 1'b1;
            s_nxt.prev = f;
            s_nxt.m.slope = s_r.primed ? sat : 16'sh0000;
            s_nxt.m.freq = f;
            s_nxt.m.pslope = s_r.hist[`RF_PRE_DEPTH-1][31:16];
            s_nxt.m.pfreq = s_r.hist[`RF_PRE_DEPTH-1][15:0];
            s_nxt.hist = {s_r.hist[`RF_PRE_DEPTH-2:0], s_nxt.m.slope, f};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign upd = s_r.upd;
    assign meas = s_r.m;
endmodule : rf_slope
`default_nettype wire

// ---- rtl/rf_stage.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rf_map.svh"
module rf_stage import rf_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic upd,
    input wire rf_stage_cfg_s cfg,
    input wire logic signed [15:0] slope,
    input wire logic [15:0] freq,
    input wire logic blk,
    input wire logic force_ok,
    output rf_stage_out_s st
);
    typedef struct packed {
        logic started;
        logic trip;
        logic blocked;
        logic [15:0] cnt;
        logic [15:0] rcnt;
        rf_stage_out_s o;
    } rf_stg_state_s;
    rf_stg_state_s s_r, s_nxt;
    logic active, forcing, pick, permit;
    logic signed [16:0] thr, sl;
    always_comb begin
        s_nxt = s_r;
        active = cfg.en & cfg.ingrp;
        forcing = force_ok & (cfg.force_st != RF_F_NORMAL);
        sl = 17'(slope);
        // release threshold sits below pick-up while started
        thr = signed'({1'b0, cfg.pick}) - (s_r.started ? 17'(`RF_HYST) : 17'sh00000);
        pick = (cfg.dir != RF_DIR_FALL && sl > thr) || (cfg.dir != RF_DIR_RISE && -sl > thr);
        permit = !cfg.lim
            || (cfg.dir != RF_DIR_FALL && freq > cfg.of_lim)
            || (cfg.dir != RF_DIR_RISE && freq < cfg.uf_lim);
        if (!active) begin
            s_nxt = '0;
        end else if (upd) begin
            s_nxt.started = pick & !blk;
            s_nxt.blocked = pick & blk;
            if (s_nxt.started) begin
                if (s_r.cnt != 16'hFFFF) begin
                    s_nxt.cnt = s_r.cnt + 16'h0001;
                end
                if (s_nxt.cnt >= cfg.op_dly && permit) begin
                    s_nxt.trip = 1'b1;
                end
                s_nxt.rcnt = 16'h0000;
            end else begin
                s_nxt.cnt = 16'h0000;
                if (s_r.trip) begin
                    s_nxt.rcnt = s_r.rcnt + 16'h0001;
                    if (s_nxt.rcnt >= cfg.rst_dly) begin
                        s_nxt.trip = 1'b0;
                        s_nxt.rcnt = 16'h0000;
                    end
                end
            end
        end
        if (!active) begin
            s_nxt.o = '0;
        end else if (forcing) begin
            unique case (cfg.force_st)
                RF_F_NORMAL: s_nxt.o = '0;
                RF_F_START: s_nxt.o = 3'b001;
                RF_F_TRIP: s_nxt.o = 3'b010;
                RF_F_BLOCKED: s_nxt.o = 3'b100;
            endcase
        end else begin
            s_nxt.o = {s_nxt.blocked, s_nxt.trip, s_nxt.started};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign st = s_r.o;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_stage_off_quiet: assert property (!active |=> st == 3'b000)
        else $error("disabled stage shows an output");
    a_force_trip_out: assert property (
        active && force_ok && cfg.force_st == RF_F_TRIP |=> st == 3'b010)
        else $error("forced trip not shown");
    a_block_at_pickup: assert property (
        upd && active && !forcing && pick && blk |=> st.blocked && !st.start)
        else $error("blocked pick-up still started");
    a_trip_needs_permit: assert property (
        upd && active && !forcing && !permit && !s_r.trip |=> !st.trip)
        else $error("trip outside the frequency limits");
    a_hyst_band_hold: assert property (
        upd && active && !forcing && !blk && s_r.started && cfg.dir == RF_DIR_RISE
        && sl <= signed'({1'b0, cfg.pick}) && sl > thr |=> st.start)
        else $error("start dropped inside hysteresis band");
endmodule : rf_stage
`default_nettype wire

// ---- test/rf_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rf_pkg::*;
    logic hclk = 0;
    logic hresetn = 0;
    logic hsel = 0;
    logic hwrite = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] rd;
    logic [1:0] htrans = 0;
    rf_refs_t fr = {3{16'h1388}};
    logic [7:0] sblk = 0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [7:0] start;
    wire logic [7:0] trip;
    wire logic [7:0] blocked;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 hclk = ~hclk;
    // short program cycle keeps the run small; each run step below lasts one program cycle
    rf_top #(.PROG_CYC(20), .MS_CYC(10)) i_rf_top (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .freq_ref(fr), .stage_block(sblk), .start(start), .trip(trip),
        .blocked(blocked));
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // address phase held until hready, then data phase until hready again
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task run(input logic [15:0] stp, input int n);
        repeat (n) begin
            fr[0] <= fr[0] + stp;
            repeat (20) @(posedge hclk);
        end
    endtask : run
    task sc_reset;
        bus(0, 32'h004, 0); chk(rd, 32'h0C8);
        bus(0, 32'h104, 0); chk(rd, 32'h14);
        bus(0, 32'h108, 0); chk(rd, 32'h13EC1383);
        bus(0, 32'h100, 0); chk(rd, 32'h0);
        bus(0, 32'h800, 0); chk(rd, 32'h0);
        run(1, 4); chk(start, 8'h0);
    endtask : sc_reset
    task sc_rise;
        bus(1, 32'h10C, 3);
        bus(1, 32'h100, 32'h41);
        run(0, 2); chk(start, 8'h0);
        run(1, 2); chk({trip[0], start[0]}, 2'b01);
        run(1, 3); chk(trip[0], 1'b1);
        run(0, 2); chk({trip[0], start[0]}, 2'b00);
    endtask : sc_rise
    task sc_dir;
        bus(1, 32'h100, 32'h49);
        run(1, 3); chk(start[0], 1'b0);
        run(16'hFFFF, 3); chk(start[0], 1'b1);
        run(0, 2);
    endtask : sc_dir
    task sc_block;
        bus(1, 32'h100, 32'h41);
        run(11, 3); chk(start[0], 1'b0);
        run(0, 2);
        sblk <= 8'h01;
        run(1, 3); chk({blocked[0], start[0]}, 2'b10);
        sblk <= 8'h00;
        run(0, 2);
    endtask : sc_block
    task sc_lim;
        // frequency sits below the overfrequency limit, so slope alone cannot trip
        bus(1, 32'h100, 32'h61);
        run(1, 4); chk(trip[0], 1'b0);
        bus(1, 32'h108, 32'h13881383);
        run(1, 4); chk(trip[0], 1'b1);
        run(0, 2);
    endtask : sc_lim
    task sc_force;
        bus(1, 32'h100, 32'h45);
        run(0, 1); chk(trip[0], 1'b0);
        bus(1, 32'h000, 32'h4);
        run(0, 1); chk(trip[0], 1'b1);
        // a clear with no edge in flight leaves all counters at zero
        bus(1, 32'h010, 0);
        bus(0, 32'h010, 0); chk(rd, 32'h0);
        bus(1, 32'h100, 32'h05);
        run(0, 1); chk(trip[0], 1'b0);
        bus(1, 32'h100, 32'h45);
        bus(1, 32'h000, 32'h0C);
        bus(1, 32'h000, 32'h4C);
        run(0, 1); chk(trip[0], 1'b0);
        bus(1, 32'h000, 32'h08);
        bus(1, 32'h000, 32'h0);
    endtask : sc_force
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1;
        sc_reset();
        sc_rise();
        sc_dir();
        sc_block();
        sc_lim();
        sc_force();
        conclude();
    end
endmodule : testbench
`default_nettype wire
